// [src/srm_pkg.sv]
// Operation
// - Pre-regulator low past deglitch time latches its undervoltage flag, bootstrap off.
// - Pre-regulator high past deglitch time latches its overvoltage flag.
// - Bootstrap is off while pre-regulator overvoltage persists past deglitch time.
// - Analog rail low past power-on-reset filter time triggers power-on reset.
// - Analog rail high past its filter time latches its overvoltage flag.
// - Communication rail low past its filter time latches its undervoltage flag.
// - Communication rail high past its filter time latches its overvoltage flag.
// - Reference rail low past its filter time latches its undervoltage flag.
// - Reference rail high past its filter time latches its overvoltage flag.
// - Digital rail low past power-on-reset filter time triggers power-on reset.
// - Digital rail high past its filter time latches its overvoltage flag.
// - Pre-regulator off in sleep, silent balancing and cyclic wakeup off phase.
// - Reference regulator off after reset, switched only by software configuration.
// - Bootstrap enabled automatically in normal mode.
// - Bootstrap alternates reload and boot phases, each of fixed length.
// - Pre-regulator soft start ramps over a bounded start-up time at power-up.
// - Analog rail overvoltage deglitch window is typically 20 microseconds.
`default_nettype none
package srm_pkg;
  localparam int CLK_MHZ = 100;
  localparam int DEGLITCH_US = 20;
  localparam int DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;
  localparam int POR_FILT_US = 20;
  localparam int POR_FILT_CYC = POR_FILT_US * CLK_MHZ;
  localparam int SOFT_START_MIN_US = 100;
  localparam int SOFT_START_MAX_US = 500;
  localparam int SOFT_START_US = 300;
  localparam int SOFT_START_CYC = SOFT_START_US * CLK_MHZ;
  localparam int RELOAD_US = 5;
  localparam int RELOAD_CYC = RELOAD_US * CLK_MHZ;
  localparam int BOOT_US = 5;
  localparam int BOOT_CYC = BOOT_US * CLK_MHZ;
  localparam int CNT_W = 16;
  // Register byte addresses
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h8;
  localparam logic [3:0] ADDR_STATE = 4'hC;
  // Fault flag bit positions
  localparam int FLG_PRE_UV = 0;
  localparam int FLG_PRE_OV = 1;
  localparam int FLG_ANA_OV = 2;
  localparam int FLG_COM_UV = 3;
  localparam int FLG_COM_OV = 4;
  localparam int FLG_REF_UV = 5;
  localparam int FLG_REF_OV = 6;
  localparam int FLG_DIG_OV = 7;
  localparam int NFLG = 8;
  localparam int CTRL_REF_EN = 0;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  typedef enum logic [2:0] {
    SRM_MODE_NORMAL = 3'h0,
    SRM_MODE_SLEEP = 3'h1,
    SRM_MODE_SILENT_BAL = 3'h2,
    SRM_MODE_CYC_OFF = 3'h3,
    SRM_MODE_CYC_ON = 3'h4
  } srm_mode_e;
  typedef enum logic [2:0] {
    SRM_BS_OFF = 3'b001,
    SRM_BS_RELOAD = 3'b010,
    SRM_BS_BOOT = 3'b100
  } srm_bs_e;
  // Raw comparator outputs, one bit per threshold
  typedef struct packed {
    logic pre_uv;
    logic pre_ov;
    logic ana_uv;
    logic ana_ov;
    logic com_uv;
    logic com_ov;
    logic ref_uv;
    logic ref_ov;
    logic dig_uv;
    logic dig_ov;
  } srm_cmp_s;
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } srm_avl_req_s;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } srm_avl_rsp_s;
endpackage
`default_nettype wire

// [src/srm_supply_rail_monitor.sv]
`default_nettype none
module srm_supply_rail_monitor #(
  parameter int DEGLITCH_CYCLES = srm_pkg::DEGLITCH_CYC,
  parameter int POR_CYCLES = srm_pkg::POR_FILT_CYC,
  parameter int SOFT_START_CYCLES = srm_pkg::SOFT_START_CYC,
  parameter int RELOAD_CYCLES = srm_pkg::RELOAD_CYC,
  parameter int BOOT_CYCLES = srm_pkg::BOOT_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire srm_pkg::srm_cmp_s cmp_raw,
  input wire srm_pkg::srm_mode_e op_mode,
  input wire srm_pkg::srm_avl_req_s avl_req,
  output srm_pkg::srm_avl_rsp_s avl_rsp,
  output logic irq,
  output logic por_req,
  output logic pre_reg_en,
  output logic [srm_pkg::CNT_W-1:0] pre_reg_ramp,
  output logic ref_reg_en,
  output logic bs_reload,
  output logic bs_boot
);
  import srm_pkg::*;

  localparam int NCMP = 10;
  localparam logic [CNT_W-1:0] DG_LIM = CNT_W'(DEGLITCH_CYCLES);
  localparam logic [CNT_W-1:0] POR_LIM = CNT_W'(POR_CYCLES);
  localparam logic [CNT_W-1:0] SS_LIM = CNT_W'(SOFT_START_CYCLES);
  localparam logic [CNT_W-1:0] RL_LIM = CNT_W'(RELOAD_CYCLES);
  localparam logic [CNT_W-1:0] BT_LIM = CNT_W'(BOOT_CYCLES);

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v,
                                               input logic [CNT_W-1:0] lim);
    sat_inc = (v >= lim) ? v : v + 16'h0001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchronisers
  logic [NCMP-1:0] cmp_s1_reg;
  logic [NCMP-1:0] cmp_s2_reg;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_s1_reg <= 10'h000;
      cmp_s2_reg <= 10'h000;
    end else if (clk_en) begin
      cmp_s1_reg <= cmp_raw;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Deglitch timers, one per comparator; a timer counts only while its
  // comparator holds and fires once the count reaches its limit
  logic [CNT_W-1:0] dg_cnt_reg [NCMP];
  logic [NCMP-1:0] dg_fire;
  logic [CNT_W-1:0] dg_lim [NCMP];
  always_comb begin
    for (int i = 0; i < NCMP; i++) begin
      dg_lim[i] = DG_LIM;
    end
    dg_lim[7] = POR_LIM;
    dg_lim[1] = POR_LIM;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NCMP; i++) begin
        dg_cnt_reg[i] <= 16'h0000;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NCMP; i++) begin
        if (!cmp_s2_reg[i]) begin
          dg_cnt_reg[i] <= 16'h0000;
        end else begin
          dg_cnt_reg[i] <= sat_inc(dg_cnt_reg[i], dg_lim[i]);
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NCMP; i++) begin
      dg_fire[i] = cmp_s2_reg[i] && (dg_cnt_reg[i] >= dg_lim[i]);
    end
  end

  // Bit order of the packed struct: pre_uv is bit 9 down to dig_ov bit 0
  logic [NFLG-1:0] evt;
  always_comb begin
    evt = 8'h00;
    evt[FLG_PRE_UV] = dg_fire[9];
    evt[FLG_PRE_OV] = dg_fire[8];
    evt[FLG_ANA_OV] = dg_fire[6];
    evt[FLG_COM_UV] = dg_fire[5];
    evt[FLG_COM_OV] = dg_fire[4];
    evt[FLG_REF_UV] = dg_fire[3];
    evt[FLG_REF_OV] = dg_fire[2];
    evt[FLG_DIG_OV] = dg_fire[0];
  end

  // Reset request is a level while either low-side filter holds
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_req <= 1'b0;
    end else if (clk_en) begin
      por_req <= dg_fire[7] | dg_fire[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait state so every access completes on the
  // second edge; reads of the status register clear it there
  logic ack_reg;
  logic [NFLG-1:0] status_reg;
  logic [NFLG-1:0] mask_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] rdata_reg;
  logic req_act;
  logic acc_done;
  assign req_act = avl_req.read | avl_req.write;
  assign acc_done = req_act & ack_reg;
  assign avl_rsp.waitrequest = req_act & ~ack_reg;
  assign avl_rsp.readdata = rdata_reg;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
    end else if (clk_en) begin
      ack_reg <= req_act & ~ack_reg;
    end
  end

  function automatic logic [31:0] rd_mux(input logic [3:0] a, input logic [NFLG-1:0] st,
                                         input logic [NFLG-1:0] mk, input logic [31:0] ct,
                                         input logic [31:0] sv);
    case (a)
      ADDR_STATUS: rd_mux = {24'h000000, st};
      ADDR_MASK: rd_mux = {24'h000000, mk};
      ADDR_CTRL: rd_mux = ct;
      ADDR_STATE: rd_mux = sv;
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction

  logic [31:0] state_word;
  srm_bs_e bs_state_reg;
  logic ss_done;
  always_comb begin
    state_word = 32'h0000_0000;
    state_word[0] = por_req;
    state_word[1] = pre_reg_en;
    state_word[2] = ss_done;
    state_word[3] = ref_reg_en;
    state_word[6:4] = bs_state_reg;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (clk_en && avl_req.read && !ack_reg) begin
      rdata_reg <= rd_mux(avl_req.address, status_reg, mask_reg, ctrl_reg, state_word);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_reg <= MASK_RST;
      ctrl_reg <= CTRL_RST;
    end else if (clk_en && avl_req.write && acc_done) begin
      if (avl_req.address == ADDR_MASK) begin
        mask_reg <= avl_req.writedata[NFLG-1:0];
      end
      if (avl_req.address == ADDR_CTRL) begin
        ctrl_reg <= {31'h0000_0000, avl_req.writedata[CTRL_REF_EN]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky fault flags: a new event wins over the read-clear
  logic st_clr;
  assign st_clr = acc_done & avl_req.read & (avl_req.address == ADDR_STATUS);
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_reg <= 8'h00;
    end else if (clk_en) begin
      status_reg <= (st_clr ? 8'h00 : status_reg) | evt;
    end
  end

  assign irq = |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Pre-regulator enable and soft start
  logic low_power;
  logic [CNT_W-1:0] ss_cnt_reg;
  always_comb begin
    case (op_mode)
      SRM_MODE_SLEEP, SRM_MODE_SILENT_BAL, SRM_MODE_CYC_OFF: low_power = 1'b1;
      default: low_power = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_reg_en <= 1'b0;
    end else if (clk_en) begin
      pre_reg_en <= ~low_power;
    end
  end

  // Ramp restarts every time the regulator is re-enabled
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ss_cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      if (!pre_reg_en) begin
        ss_cnt_reg <= 16'h0000;
      end else begin
        ss_cnt_reg <= sat_inc(ss_cnt_reg, SS_LIM);
      end
    end
  end
  assign ss_done = (ss_cnt_reg >= SS_LIM);
  assign pre_reg_ramp = ss_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Reference regulator: software only
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_reg_en <= 1'b0;
    end else if (clk_en) begin
      ref_reg_en <= ctrl_reg[CTRL_REF_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bootstrap two-phase pump; UV latch or live OV holds it off
  logic bs_allow;
  logic [CNT_W-1:0] bs_cnt_reg;
  assign bs_allow = (op_mode == SRM_MODE_NORMAL) & pre_reg_en & ss_done
                    & ~status_reg[FLG_PRE_UV]
                    & ~dg_fire[8];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bs_state_reg <= SRM_BS_OFF;
      bs_cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      if (!bs_allow) begin
        bs_state_reg <= SRM_BS_OFF;
        bs_cnt_reg <= 16'h0000;
      end else begin
        case (bs_state_reg)
          SRM_BS_OFF: begin
            bs_state_reg <= SRM_BS_RELOAD;
            bs_cnt_reg <= 16'h0000;
          end
          SRM_BS_RELOAD: begin
            if (bs_cnt_reg >= RL_LIM - 16'h0001) begin
              bs_state_reg <= SRM_BS_BOOT;
              bs_cnt_reg <= 16'h0000;
            end else begin
              bs_cnt_reg <= bs_cnt_reg + 16'h0001;
            end
          end
          SRM_BS_BOOT: begin
            if (bs_cnt_reg >= BT_LIM - 16'h0001) begin
              bs_state_reg <= SRM_BS_RELOAD;
              bs_cnt_reg <= 16'h0000;
            end else begin
              bs_cnt_reg <= bs_cnt_reg + 16'h0001;
            end
          end
          default: begin
            bs_state_reg <= SRM_BS_OFF;
            bs_cnt_reg <= 16'h0000;
          end
        endcase
      end
    end
  end

  assign bs_reload = (bs_state_reg == SRM_BS_RELOAD);
  assign bs_boot = (bs_state_reg == SRM_BS_BOOT);
endmodule
`default_nettype wire

// [testbench/srm_supply_rail_monitor_chk.sv]
`default_nettype none
module srm_supply_rail_monitor_chk #(
  parameter int DEGLITCH_CYCLES = 8,
  parameter int POR_CYCLES = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire srm_pkg::srm_cmp_s cmp_raw,
  input wire srm_pkg::srm_mode_e op_mode,
  input wire srm_pkg::srm_avl_req_s avl_req,
  input wire logic por_req,
  input wire logic pre_reg_en,
  input wire logic [srm_pkg::CNT_W-1:0] pre_reg_ramp,
  input wire logic ref_reg_en,
  input wire logic bs_reload,
  input wire logic bs_boot
);
  import srm_pkg::*;
  int ov_run_reg;
  int por_run_reg;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // Runs count raw levels; the two sync flops are covered by margins below
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ov_run_reg <= 0;
    end else begin
      ov_run_reg <= cmp_raw.pre_ov ? ov_run_reg + 1 : 0;
    end
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_run_reg <= 0;
    end else begin
      por_run_reg <= (cmp_raw.ana_uv || cmp_raw.dig_uv) ? por_run_reg + 1 : 0;
    end
  end
  ////////////////////////////////////////
  sequence s_low_mode;
    clk_en && op_mode inside {SRM_MODE_SLEEP, SRM_MODE_SILENT_BAL, SRM_MODE_CYC_OFF};
  endsequence
  sequence s_boot_end;
    ##[1:6] !bs_boot;
  endsequence
  property p_pre_off; s_low_mode |=> !pre_reg_en; endproperty
  property p_pre_on; clk_en && op_mode inside {SRM_MODE_NORMAL, SRM_MODE_CYC_ON} |=> pre_reg_en;
  endproperty
  property p_ramp_zero; !pre_reg_en ##1 !pre_reg_en |-> pre_reg_ramp == '0; endproperty
  property p_bs_mode; clk_en && op_mode != SRM_MODE_NORMAL |=> !bs_reload && !bs_boot; endproperty
  property p_bs_ov; ov_run_reg > DEGLITCH_CYCLES + 4 |-> !bs_reload && !bs_boot; endproperty
  property p_bs_excl; !(bs_reload && bs_boot); endproperty
  property p_boot_len; $rose(bs_boot) |-> s_boot_end; endproperty
  property p_por_rise; $rose(por_req) |-> por_run_reg >= POR_CYCLES; endproperty
  property p_por_hold; por_run_reg > POR_CYCLES + 4 |-> por_req; endproperty
  property p_por_clr; (!cmp_raw.ana_uv && !cmp_raw.dig_uv) [*5] |-> !por_req; endproperty
  property p_ref; $changed(ref_reg_en) |-> $past(avl_req.write) || $past(avl_req.write, 2);
  endproperty
  a_pre_off: assert property (p_pre_off) else $error("pre-regulator on");
  a_pre_on: assert property (p_pre_on) else $error("pre-regulator off");
  a_ramp_zero: assert property (p_ramp_zero) else $error("ramp not cleared");
  a_bs_mode: assert property (p_bs_mode) else $error("bootstrap outside normal");
  a_bs_ov: assert property (p_bs_ov) else $error("bootstrap on in overvoltage");
  a_bs_excl: assert property (p_bs_excl) else $error("both phases on");
  a_boot_len: assert property (p_boot_len) else $error("boot phase too long");
  a_por_rise: assert property (p_por_rise) else $error("reset too early");
  a_por_hold: assert property (p_por_hold) else $error("reset missing");
  a_por_clr: assert property (p_por_clr) else $error("reset stuck");
  a_ref: assert property (p_ref) else $error("reference enable moved alone");
endmodule
bind srm_supply_rail_monitor srm_supply_rail_monitor_chk #(
  .DEGLITCH_CYCLES(DEGLITCH_CYCLES), .POR_CYCLES(POR_CYCLES)) u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .cmp_raw(cmp_raw),
  .op_mode(op_mode), .avl_req(avl_req), .por_req(por_req), .pre_reg_en(pre_reg_en),
  .pre_reg_ramp(pre_reg_ramp), .ref_reg_en(ref_reg_en), .bs_reload(bs_reload),
  .bs_boot(bs_boot));
`default_nettype wire

// [testbench/srm_supply_rail_monitor_tb.sv]
`default_nettype none
module srm_supply_rail_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import srm_pkg::*;
  localparam int DEG = 8;
  localparam int POR = 8;
  localparam int SS = 16;
  localparam int PH = 4;
  localparam int RAWB [8] = '{9, 8, 6, 5, 4, 3, 2, 0};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  srm_cmp_s cmp_raw = '0;
  srm_mode_e op_mode = SRM_MODE_NORMAL;
  srm_avl_req_s avl_req = '0;
  srm_avl_rsp_s avl_rsp;
  logic irq, por_req, pre_reg_en, ref_reg_en, bs_reload, bs_boot;
  logic [CNT_W-1:0] pre_reg_ramp;
  logic [31:0] rd;
  int miscompares = 0;
  int checks = 0;
  int n;
  int k;
  srm_supply_rail_monitor #(.DEGLITCH_CYCLES(DEG), .POR_CYCLES(POR), .SOFT_START_CYCLES(SS),
    .RELOAD_CYCLES(PH), .BOOT_CYCLES(PH)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .cmp_raw(cmp_raw),
    .op_mode(op_mode), .avl_req(avl_req), .avl_rsp(avl_rsp), .irq(irq), .por_req(por_req),
    .pre_reg_en(pre_reg_en), .pre_reg_ramp(pre_reg_ramp), .ref_reg_en(ref_reg_en),
    .bs_reload(bs_reload), .bs_boot(bs_boot));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected pin at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  // Waitrequest is read right after each edge, before that edge's updates land,
  // so the value seen is the one the slave showed at the edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avl_req.address <= a;
    avl_req.write <= wr;
    avl_req.read <= !wr;
    avl_req.writedata <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (n > 20) begin
        miscompares++;
        give_verdict();
      end
    end while (avl_rsp.waitrequest !== 1'b0);
    rd = avl_rsp.readdata;
    avl_req.read <= 1'b0;
    avl_req.write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk_rd(rd, exp);
  endtask
  task automatic run_len(input logic boot, output int c);
    c = 0;
    while ((boot ? bs_boot : bs_reload) === 1'b1 && c < 50) begin
      @(negedge core_clk);
      c++;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    tick(8);
    sys_rst <= 1'b0;
    tick(1);
    chk_pin(ref_reg_en, 1'b0);
    rd_chk(ADDR_MASK, 32'h0);
    rd_chk(ADDR_CTRL, 32'h0);
    bus(1'b1, 4'h6, 32'hFF);
    rd_chk(4'h6, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h1);
    tick(2);
    chk_pin(ref_reg_en, 1'b1);
    bus(1'b1, ADDR_CTRL, 32'h0);
    tick(2);
    chk_pin(ref_reg_en, 1'b0);
    for (int m = 1; m <= 5; m++) begin
      op_mode <= srm_mode_e'(m % 5);
      tick(3);
      chk_pin(pre_reg_en, m > 3);
      chk_pin(bs_reload | bs_boot, 1'b0);
      if (m < 4) begin
        chk_pin(pre_reg_ramp == '0, 1'b1);
      end
    end
    tick(SS + 4);
    chk_rd(pre_reg_ramp, SS);
    // Pump is running by now, so the phase bits are reload or boot
    bus(1'b0, ADDR_STATE, 32'h0);
    chk_rd(rd & 32'hFFFF_FF8F, 32'h6);
    chk_rd(rd[6:4] == 3'b010 || rd[6:4] == 3'b100, 32'h1);
    // Let any boot phase already under way finish so the next one is timed whole
    run_len(1'b1, k);
    n = 0;
    while (bs_boot !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    chk_pin(bs_boot, 1'b1);
    run_len(1'b1, k);
    chk_rd(k, PH);
    run_len(1'b0, k);
    chk_rd(k, PH);
    chk_pin(bs_boot, 1'b1);
    // Bit 0 stays masked so one flag proves the mask gates the interrupt
    bus(1'b1, ADDR_MASK, 32'hFE);
    for (int i = 0; i < NFLG; i++) begin
      cmp_raw[RAWB[i]] <= 1'b1;
      tick(DEG);
      cmp_raw[RAWB[i]] <= 1'b0;
      tick(4);
      rd_chk(ADDR_STATUS, 32'h0);
      cmp_raw[RAWB[i]] <= 1'b1;
      tick(DEG + 8);
      if (i < 2) begin
        chk_pin(bs_reload | bs_boot, 1'b0);
      end
      cmp_raw[RAWB[i]] <= 1'b0;
      tick(6);
      chk_pin(irq, i != 0);
      rd_chk(ADDR_STATUS, 32'h1 << i);
      rd_chk(ADDR_STATUS, 32'h0);
      chk_pin(irq, 1'b0);
    end
    for (int b = 0; b < 2; b++) begin
      cmp_raw[b ? 1 : 7] <= 1'b1;
      tick(POR);
      cmp_raw[b ? 1 : 7] <= 1'b0;
      tick(3);
      chk_pin(por_req, 1'b0);
      cmp_raw[b ? 1 : 7] <= 1'b1;
      tick(POR + 8);
      chk_pin(por_req, 1'b1);
      cmp_raw[b ? 1 : 7] <= 1'b0;
      tick(6);
      chk_pin(por_req, 1'b0);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
